// File: hdl/intc_defines.svh
// Offsets, field positions, reset values, vector types and timing counts
`ifndef INTC_DEFINES_SVH
`define INTC_DEFINES_SVH
`define OFF_CTRL0 8'h00
`define OFF_THRESH 8'h20
`define OFF_INSERV 8'h24
`define OFF_REQ 8'h28
`define OFF_STAT 8'h2C
`define CTRL_W 7
`define LVL_W 3
`define F_LVL 0
`define F_MASK 3
`define F_LTRIG 4
`define F_CASC 5
`define F_SNEST 6
`define CTRL_RST 7'h0F
`define CTRL_INT_BITS 7'h0F
`define CTRL_PIN_BITS 7'h1F
`define CTRL_PAIR_BITS 7'h7F
`define THRESH_RST 3'h7
`define STAT_PEND 15
`define SRC_PIN0 3'h3
`define SRC_PIN1 3'h4
`define SRC_PIN2 3'h5
`define SRC_PIN3 3'h6
`define VT_DIV 8'h00
`define VT_STEP 8'h01
`define VT_NMI 8'h02
`define VT_BRK 8'h03
`define VT_OVF 8'h04
`define VT_RANGE 8'h05
`define VT_UNDEF 8'h06
`define VT_ESCAPE 8'h07
`define VT_TIMER 8'h08
`define VT_DMA0 8'h0A
`define VT_DMA1 8'h0B
`define VT_PIN0 8'h0C
`define ESCAPE_TOP 5'h1B
`define GAP_IDLES 2'h2
`define VEC_SHIFT 2
`endif

// File: hdl/intc_pkg.sv
// Types shared by the interrupt priority and acknowledge block
package intc_pkg;
	typedef enum logic [2:0] {st_idle, st_ale1, st_cyc1, st_gap, st_ale2, st_cyc2} ack_state_type;
	typedef enum logic [2:0] {kind_none, kind_step, kind_nmi, kind_exc, kind_mask} grant_kind_type;
endpackage : intc_pkg

// File: hdl/urgency_resolver.sv
// Picks one winner among pending maskable sources
`timescale 1ns/1ns
`include "intc_defines.svh"
module urgency_resolver import intc_pkg::*; #(
	parameter int NSRC = 8,
	parameter int IDXW = 3
) (
	// Candidates and their levels
	input wire logic [NSRC-1:0] cand,
	input wire logic [NSRC*`LVL_W-1:0] levels,
	// Winner
	output logic win_valid,
	output logic [IDXW-1:0] win_idx,
	output logic [`LVL_W-1:0] win_lvl
);
	always_comb begin
		win_valid = 1'b0;
		win_idx = '0;
		win_lvl = '1;
		for (int i = 0; i < NSRC; i++) begin
			// Strict compare keeps the lower index on a tie
			if (cand[i] && (!win_valid || levels[i*`LVL_W +: `LVL_W] < win_lvl)) begin // R1
				win_valid = 1'b1;
				win_idx = IDXW'(i);
				win_lvl = levels[i*`LVL_W +: `LVL_W];
			end
		end
	end
endmodule : urgency_resolver

// File: hdl/ack_sequencer.sv
// Two locked acknowledge bus cycles that fetch an external vector type
`timescale 1ns/1ns
`include "intc_defines.svh"
module ack_sequencer import intc_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic ce,
	// Control
	input wire logic start,
	output logic busy,
	output logic done_q,
	output logic [7:0] vtype_q,
	// Bus side
	input wire logic ready,
	input wire logic [7:0] ad_in,
	output logic ale,
	output logic ack_active
);
	ack_state_type st_q;
	logic [1:0] gap_q;

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			st_q <= st_idle;
			gap_q <= 2'h0;
		end else if (ce) begin
			case (st_q)
				st_idle: if (start) st_q <= st_ale1;
				st_ale1: st_q <= st_cyc1;
				st_cyc1: if (ready) begin // R16
					st_q <= st_gap;
					gap_q <= `GAP_IDLES;
				end
				st_gap: begin
					gap_q <= gap_q - 2'h1;
					if (gap_q == 2'h1) st_q <= st_ale2; // R16
				end
				st_ale2: st_q <= st_cyc2;
				st_cyc2: if (ready) st_q <= st_idle; // R16
				default: st_q <= st_idle;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			done_q <= 1'b0;
			vtype_q <= 8'h00;
		end else if (ce) begin
			done_q <= (st_q == st_cyc2) && ready;
			if ((st_q == st_cyc2) && ready) vtype_q <= ad_in; // R15
		end
	end

	// Address latch strobe leads each acknowledge cycle
	assign ale = (st_q == st_ale1) || (st_q == st_ale2); // R17
	assign ack_active = (st_q == st_cyc1) || (st_q == st_cyc2);
	assign busy = (st_q != st_idle);

	a_two_idle_gap: assert property (@(posedge sys_clk) disable iff (!rstn || !ce)
		(st_q == st_cyc1 && ready) |=> (!ack_active && !ale)[*2] ##1 ale) // R16
		else $error("acknowledge cycles not separated by two idles");
	a_ale_leads: assert property (@(posedge sys_clk) disable iff (!rstn || !ce)
		$rose(ack_active) |-> $past(ale)) // R17
		else $error("acknowledge cycle without address latch strobe");
	a_type_taken: assert property (@(posedge sys_clk) disable iff (!rstn || !ce)
		(st_q == st_cyc2 && ready) |=> (done_q && vtype_q == $past(ad_in))) // R15
		else $error("vector type not taken in second cycle");
	c_ext_fetch: cover property (@(posedge sys_clk) disable iff (!rstn) done_q);
endmodule : ack_sequencer

// File: hdl/intc_top.sv
// Interrupt priority resolution and acknowledge control
// Notes on behaviour
// R1 - Maskable sources from type 8 rank by programmable level, then fixed order.
// R2 - Each source has level zero to seven, zero most urgent; reset gives seven.
// R3 - Equal levels grant request pins in order pin 0, pin 1, pin 2 onward.
// R4 - Single-step flag raises type 01h after instructions except prefix, segment, wait.
// R5 - Single-step flag is cleared only after flags are pushed; return restores it.
// R6 - Nonmaskable pin acts on rising edge only, type 02h; high at reset ignored.
// R7 - Nonmaskable request skips maskable resolution, no in-service bit, may preempt itself.
// R8 - Divide quotient overflow raises type 00h.
// R9 - One-byte breakpoint instruction raises type 03h.
// R10 - Overflow-trap instruction with overflow flag set raises type 04h.
// R11 - Range-check failure raises type 05h.
// R12 - Undefined opcode raises type 06h.
// R13 - Escape opcodes D8h-DFh always trap to 07h, restart at instruction or prefix.
// R14 - Internally supplied type runs no acknowledge bus cycles.
// R15 - External type runs two acknowledge cycles; type read from low lines in second.
// R16 - Acknowledge cycles are locked, two idles between, ready inserts waits.
// R17 - Each acknowledge cycle pulses address latch strobe, read strobe stays inactive.
// R18 - Reset clears nesting, level-trigger, linked bits, in-service and request bits.
// R19 - Reset sets all levels to 7, all masks to 1, threshold to 7.
// R20 - Five pins: five direct, one pair plus three, or two pairs plus pin 4.
// R21 - Pin configuration from pin 0 and 1 controls; internal sources unaffected.
// R22 - Vector table address is type shifted left two.
// R23 - Grant only enabled source with no higher request pending or in service.
// R24 - Fully nested: same or lower source blocked by equal or higher in-service bit.
// R25 - Edge mode latches request on rising pin, clears on acknowledge.
// R26 - Exactly one maskable winner per pass, level first then fixed order.
//
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ns
`include "intc_defines.svh"
module intc_top import intc_pkg::*; #(
	parameter int NSRC = 8,
	parameter int IDXW = 3
) (
	// Clock, reset and enable
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic ce,
	// Wishbone slave
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Internal maskable sources, one-cycle pulses
	input wire logic timer_irq,
	input wire logic dma0_irq,
	input wire logic dma1_irq,
	// Request pins
	input wire logic request_pin_0,
	input wire logic request_pin_1,
	input wire logic request_pin_2,
	input wire logic request_pin_3,
	input wire logic request_pin_4,
	input wire logic nmi_pin,
	// Acknowledge pins shared with pins 2 and 3
	output logic acknowledge_pin_0_n,
	output logic acknowledge_pin_0_oe_n,
	output logic acknowledge_pin_1_n,
	output logic acknowledge_pin_1_oe_n,
	// Acknowledge bus
	input wire logic ready,
	input wire logic [7:0] low_address_data_lines,
	output logic ale,
	output logic rd_n,
	output logic bus_locked,
	// Core events
	input wire logic int_enable,
	input wire logic instr_done,
	input wire logic single_step_flag,
	input wire logic instr_prefix,
	input wire logic instr_seg_write,
	input wire logic instr_wait,
	input wire logic div_overflow,
	input wire logic breakpoint_instr,
	input wire logic overflow_trap_instr,
	input wire logic overflow_flag,
	input wire logic range_fail,
	input wire logic undefined_opcode,
	input wire logic opcode_valid,
	input wire logic [7:0] opcode,
	input wire logic flags_pushed,
	// Core handshake
	input wire logic int_take,
	output logic int_req,
	output logic vector_valid_q,
	output logic [7:0] vector_type_q,
	output logic [9:0] vector_addr_q,
	output logic restart_at_start_q,
	output logic single_step_clear_q
);
	logic [`CTRL_W-1:0] ctrl_q [NSRC];
	logic [`LVL_W-1:0] lvl [NSRC];
	logic [`LVL_W-1:0] thresh_q;
	logic [NSRC-1:0] ins_q, req_q, src_prev_q, src_raw, src_live, mask_v, cand, grant_hot;
	logic [NSRC*`LVL_W-1:0] lvl_flat;
	logic win_valid, win_ext, blocked, mask_ok, take, casc0, casc1, pair_q, wait_q;
	logic [IDXW-1:0] win_idx;
	logic [`LVL_W-1:0] win_lvl;
	logic nmi_prev_q, nmi_pend_q, step_pend_q, exc_pend_q, escape_pend_q, trace_taken_q;
	logic [7:0] exc_type_q, vt_d;
	logic ack_q, wr, seq_busy, seq_done, ack_active, better;
	logic [7:0] seq_type;
	logic [31:0] rd_data;
	logic [IDXW:0] slot;
	grant_kind_type grant_kind;

	function automatic logic [IDXW:0] ctrl_slot(input logic [7:0] adr);
		logic [7:0] rel;
		rel = adr - `OFF_CTRL0;
		ctrl_slot = {(rel[7:IDXW+2] == '0) && (rel[1:0] == 2'h0), rel[IDXW+1:2]};
	endfunction : ctrl_slot

	function automatic logic [7:0] src_type(input logic [IDXW-1:0] idx);
		case (idx)
			3'h0: src_type = `VT_TIMER; // R1
			3'h1: src_type = `VT_DMA0;
			3'h2: src_type = `VT_DMA1;
			default: src_type = `VT_PIN0 + 8'(idx - `SRC_PIN0);
		endcase
	endfunction : src_type

	function automatic logic [`CTRL_W-1:0] wr_bits(input logic [IDXW-1:0] idx);
		if (idx == `SRC_PIN0 || idx == `SRC_PIN1) wr_bits = `CTRL_PAIR_BITS; // R21
		else if (idx >= `SRC_PIN0) wr_bits = `CTRL_PIN_BITS;
		else wr_bits = `CTRL_INT_BITS;
	endfunction : wr_bits

	// Fixed order: timer, dma 0, dma 1, then pins 0 to 4
	assign src_raw = {request_pin_4, request_pin_3, request_pin_2, request_pin_1, request_pin_0,
		dma1_irq, dma0_irq, timer_irq}; // R3
	assign casc0 = ctrl_q[`SRC_PIN0][`F_CASC]; // R21
	assign casc1 = ctrl_q[`SRC_PIN1][`F_CASC]; // R21
	// Pins 2 and 3 become acknowledge outputs in a linked pair
	always_comb begin
		src_live = '1;
		src_live[`SRC_PIN2] = !casc0; // R20
		src_live[`SRC_PIN3] = !casc1; // R20
	end

	// Wishbone slave, one wait state, write lands on the acked edge
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];
	assign wb_ack_o = ack_q;
	assign slot = ctrl_slot(wb_adr_i);

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			ack_q <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (ce) begin
			ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
			if (wb_cyc_i && wb_stb_i && !ack_q) wb_dat_o <= rd_data;
		end
	end

	always_comb begin
		rd_data = 32'h0000_0000;
		if (slot[IDXW]) rd_data = 32'(ctrl_q[slot[IDXW-1:0]]);
		else begin
			case (wb_adr_i)
				`OFF_THRESH: rd_data = 32'(thresh_q);
				`OFF_INSERV: rd_data = 32'(ins_q);
				`OFF_REQ: rd_data = 32'(req_q);
				`OFF_STAT: rd_data = (32'(mask_ok) << `STAT_PEND) | 32'(src_type(win_idx));
				default: rd_data = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			for (int i = 0; i < NSRC; i++) ctrl_q[i] <= `CTRL_RST; // R18 R19
			thresh_q <= `THRESH_RST; // R19
		end else if (ce && wr) begin
			if (slot[IDXW]) ctrl_q[slot[IDXW-1:0]] <= wb_dat_i[`CTRL_W-1:0] & wr_bits(slot[IDXW-1:0]);
			if (wb_adr_i == `OFF_THRESH) thresh_q <= wb_dat_i[`LVL_W-1:0];
		end
	end

	// Request latching per source
	for (genvar g = 0; g < NSRC; g++) begin : g_src
		assign lvl[g] = ctrl_q[g][`F_LVL +: `LVL_W]; // R2
		assign lvl_flat[g*`LVL_W +: `LVL_W] = lvl[g];
		assign mask_v[g] = ctrl_q[g][`F_MASK];
		always_ff @(posedge sys_clk) begin
			if (!rstn) begin
				req_q[g] <= 1'b0; // R18
				src_prev_q[g] <= 1'b0;
			end else if (ce) begin
				src_prev_q[g] <= src_raw[g];
				if (ctrl_q[g][`F_LTRIG]) req_q[g] <= src_raw[g];
				else req_q[g] <= (req_q[g] && !grant_hot[g]) || (src_raw[g] && !src_prev_q[g]); // R25
			end
		end
	end

	assign cand = req_q & ~mask_v & src_live; // R23

	urgency_resolver #(
		.NSRC(NSRC),
		.IDXW(IDXW)
	) u_resolver (
		.cand(cand),
		.levels(lvl_flat),
		.win_valid(win_valid),
		.win_idx(win_idx),
		.win_lvl(win_lvl)
	);

	// Nesting check against every in-service source
	always_comb begin
		blocked = 1'b0;
		for (int s = 0; s < NSRC; s++) begin
			if (ins_q[s]) begin
				if (IDXW'(s) == win_idx) begin
					if (!ctrl_q[s][`F_SNEST]) blocked = 1'b1; // R24
				end else if (lvl[s] < win_lvl || (lvl[s] == win_lvl && IDXW'(s) < win_idx)) begin
					blocked = 1'b1; // R23 R24
				end
			end
		end
	end

	assign mask_ok = win_valid && (win_lvl <= thresh_q) && !blocked && int_enable; // R23 R26
	assign win_ext = (win_idx == `SRC_PIN0 && casc0) || (win_idx == `SRC_PIN1 && casc1); // R15

	// Trace first, then nonmaskable pin, then exceptions, then maskable
	always_comb begin
		if (step_pend_q) grant_kind = kind_step;
		else if (nmi_pend_q) grant_kind = kind_nmi; // R7
		else if (exc_pend_q) grant_kind = kind_exc;
		else if (mask_ok) grant_kind = kind_mask;
		else grant_kind = kind_none;
	end

	assign int_req = (grant_kind != kind_none) && !seq_busy && !wait_q;
	assign take = int_take && int_req && ce;
	assign grant_hot = (take && grant_kind == kind_mask) ? (NSRC'(1) << win_idx) : '0;

	always_ff @(posedge sys_clk) begin
		if (!rstn) ins_q <= '0; // R18
		else if (ce) begin
			// A grant in the same cycle as a clear keeps the bit set
			if (wr && wb_adr_i == `OFF_INSERV) ins_q <= (ins_q & ~wb_dat_i[NSRC-1:0]) | grant_hot;
			else ins_q <= ins_q | grant_hot;
		end
	end

	// Nonmaskable pin; reset value of one hides a pin held high
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			nmi_prev_q <= 1'b1; // R6
			nmi_pend_q <= 1'b0;
		end else if (ce) begin
			nmi_prev_q <= nmi_pin;
			nmi_pend_q <= (nmi_pend_q && !(take && grant_kind == kind_nmi)) || (nmi_pin && !nmi_prev_q); // R6 R7
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) step_pend_q <= 1'b0;
		else if (ce) begin
			step_pend_q <= (step_pend_q && !(take && grant_kind == kind_step)) ||
				(instr_done && single_step_flag && !instr_prefix && !instr_seg_write && !instr_wait); // R4
		end
	end

	// Flag clear waits for the flags push so the saved copy keeps it set
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			trace_taken_q <= 1'b0;
			single_step_clear_q <= 1'b0;
		end else if (ce) begin
			single_step_clear_q <= trace_taken_q && flags_pushed; // R5
			if (take && grant_kind == kind_step) trace_taken_q <= 1'b1;
			else if (flags_pushed) trace_taken_q <= 1'b0; // R5
		end
	end

	// Instruction exceptions are exclusive, one held at a time
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			exc_pend_q <= 1'b0;
			escape_pend_q <= 1'b0;
			exc_type_q <= `VT_DIV;
		end else if (ce) begin
			if (take && grant_kind == kind_exc) exc_pend_q <= 1'b0;
			if (div_overflow) exc_type_q <= `VT_DIV; // R8
			else if (breakpoint_instr) exc_type_q <= `VT_BRK; // R9
			else if (overflow_trap_instr && overflow_flag) exc_type_q <= `VT_OVF; // R10
			else if (range_fail) exc_type_q <= `VT_RANGE; // R11
			else if (undefined_opcode) exc_type_q <= `VT_UNDEF; // R12
			else if (opcode_valid && opcode[7:3] == `ESCAPE_TOP) exc_type_q <= `VT_ESCAPE; // R13
			if (div_overflow || breakpoint_instr || (overflow_trap_instr && overflow_flag) || range_fail ||
				undefined_opcode || (opcode_valid && opcode[7:3] == `ESCAPE_TOP)) begin
				exc_pend_q <= 1'b1;
				escape_pend_q <= !div_overflow && !breakpoint_instr && !(overflow_trap_instr && overflow_flag) &&
					!range_fail && !undefined_opcode; // R13
			end
		end
	end

	always_comb begin
		case (grant_kind)
			kind_step: vt_d = `VT_STEP; // R4
			kind_nmi: vt_d = `VT_NMI; // R6
			kind_exc: vt_d = exc_type_q;
			kind_mask: vt_d = src_type(win_idx); // R14
			default: vt_d = `VT_DIV;
		endcase
	end

	// Vector delivery; external types wait for the acknowledge pair
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			vector_valid_q <= 1'b0;
			vector_type_q <= `VT_DIV;
			vector_addr_q <= 10'h000;
			restart_at_start_q <= 1'b0;
			pair_q <= 1'b0;
			wait_q <= 1'b0;
		end else if (ce) begin
			vector_valid_q <= 1'b0;
			if (seq_done) begin
				vector_valid_q <= 1'b1;
				vector_type_q <= seq_type; // R15
				vector_addr_q <= 10'(seq_type) << `VEC_SHIFT; // R22
				restart_at_start_q <= 1'b0;
				wait_q <= 1'b0;
			end else if (take && grant_kind == kind_mask && win_ext) begin
				pair_q <= (win_idx == `SRC_PIN1);
				wait_q <= 1'b1;
			end else if (take) begin
				vector_valid_q <= 1'b1;
				vector_type_q <= vt_d;
				vector_addr_q <= 10'(vt_d) << `VEC_SHIFT; // R22
				restart_at_start_q <= (grant_kind == kind_exc) && escape_pend_q; // R13
			end
		end
	end

	ack_sequencer u_ack (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.ce(ce),
		.start(take && grant_kind == kind_mask && win_ext), // R14 R15
		.busy(seq_busy),
		.done_q(seq_done),
		.vtype_q(seq_type),
		.ready(ready),
		.ad_in(low_address_data_lines),
		.ale(ale),
		.ack_active(ack_active)
	);

	assign acknowledge_pin_0_n = !(ack_active && !pair_q); // R15
	assign acknowledge_pin_1_n = !(ack_active && pair_q); // R15
	assign acknowledge_pin_0_oe_n = !casc0; // R20
	assign acknowledge_pin_1_oe_n = !casc1; // R20
	assign rd_n = 1'b1; // R17
	assign bus_locked = seq_busy; // R16

	// Helper: any candidate ranked above the winner
	always_comb begin
		better = 1'b0;
		for (int j = 0; j < NSRC; j++) begin
			if (cand[j] && (lvl[j] < win_lvl || (lvl[j] == win_lvl && IDXW'(j) < win_idx))) better = 1'b1;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	a_reset_levels: assert property ($rose(rstn) |-> (thresh_q == `THRESH_RST && ctrl_q[0] == `CTRL_RST &&
		ctrl_q[NSRC-1] == `CTRL_RST)) // R19
		else $error("levels, masks or threshold wrong after reset");
	a_reset_clear: assert property ($rose(rstn) |-> (ins_q == '0 && req_q == '0 && !casc0 && !casc1)) // R18
		else $error("control or request state not cleared by reset");
	a_winner_best: assert property (win_valid |-> (!better && cand[win_idx])) // R1
		else $error("winner is not the best ranked candidate");
	a_nmi_edge: assert property ((ce && nmi_pin && !nmi_prev_q) |=> nmi_pend_q) // R6
		else $error("rising nonmaskable edge lost");
	a_nmi_reset_high: assert property (($rose(rstn) && nmi_pin && ce) |=> !nmi_pend_q) // R6
		else $error("pin held high at reset raised a request");
	a_step_raise: assert property ((ce && instr_done && single_step_flag && !instr_prefix && !instr_seg_write &&
		!instr_wait) |=> step_pend_q) // R4
		else $error("single step not raised");
	a_nmi_no_service: assert property ((take && grant_kind == kind_nmi && !wr) |=> ins_q == $past(ins_q)) // R7
		else $error("nonmaskable grant touched in-service bits");
	a_internal_no_ack: assert property ((take && grant_kind == kind_mask && !win_ext) |=>
		(vector_valid_q && !ack_active && !ale)) // R14
		else $error("internal type ran acknowledge cycles");
	a_nest_guard: assert property ((grant_kind == kind_mask) |-> !(ins_q[win_idx] && !ctrl_q[win_idx][`F_SNEST])) // R24
		else $error("same source granted while in service");
	a_step_clear: assert property (single_step_clear_q |-> $past(flags_pushed, 1)) // R5
		else $error("single step flag cleared before flags were saved");
	a_vec_index: assert property (vector_valid_q |-> vector_addr_q[9:`VEC_SHIFT] == vector_type_q) // R22
		else $error("vector address not type times four");

	c_nmi_preempts: cover property (take && grant_kind == kind_nmi && ins_q != '0);
	c_ext_ack: cover property (take && grant_kind == kind_mask && win_ext);
	c_level_win: cover property (win_valid && win_lvl < `THRESH_RST);
endmodule : intc_top

// File: test/ext_ctrl_model.sv
// Behavioural external vector controller answering the acknowledge cycles
`timescale 1ns/1ns
module ext_ctrl_model (
	// Bus side
	input wire logic sys_clk,
	input wire logic ack_n,
	output logic ready,
	output logic [7:0] lines,
	// Type to hand over
	input wire logic [7:0] vtype
);
	logic second_q = 1'h0;
	initial ready = 1'h1;
	// Random waits stretch some of the acknowledge cycles
	always @(posedge sys_clk) begin
		ready <= 1'($urandom_range(1, 0));
		if (!ack_n && ready)
			second_q <= !second_q;
	end
	// Type only in the second cycle; the inverse elsewhere so stale data cannot pass
	assign lines = (second_q && !ack_n) ? vtype : ~vtype;
endmodule : ext_ctrl_model

// File: test/interrupt_priority_and_ack_tb.sv
// Self-checking bench for interrupt priority resolution and acknowledge
`timescale 1ns/1ns
module interrupt_priority_and_ack_tb;
	logic sys_clk = 1'h0, rstn = 1'h0, ce = 1'h1, wb_we_i = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
	logic [7:0] wb_adr_i = 8'h00, vt = 8'h00, opcode = 8'h00, low_address_data_lines, vector_type_q;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
	logic [3:0] wb_sel_i = 4'hF;
	logic [4:0] pins = 5'h00;
	logic [5:0] ev = 6'h00;
	logic [2:0] tr = 3'h0;
	logic [9:0] vector_addr_q;
	logic timer_irq = 1'h0, dma0_irq = 1'h0, dma1_irq = 1'h0, nmi_pin = 1'h1, int_enable = 1'h1;
	logic instr_done = 1'h0, single_step_flag = 1'h0, overflow_flag = 1'h1, flags_pushed = 1'h0, int_take = 1'h0;
	logic wb_ack_o, acknowledge_pin_0_n, acknowledge_pin_0_oe_n, acknowledge_pin_1_n, acknowledge_pin_1_oe_n;
	logic ready, ale, rd_n, bus_locked, int_req, vector_valid_q, restart_at_start_q, single_step_clear_q;
	int mismatches = 0, checks = 0, cyc = 0, n, lv;
	localparam logic [7:0] exc_t [6] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07};
	localparam logic [7:0] mt [4] = '{8'h08, 8'h0C, 8'h0D, 8'h0E};
	localparam int mi [4] = '{0, 3, 4, 5};
	intc_top i_dut (.sys_clk, .rstn, .ce, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
		.wb_dat_o, .wb_ack_o, .timer_irq, .dma0_irq, .dma1_irq, .request_pin_0(pins[0]), .request_pin_1(pins[1]),
		.request_pin_2(pins[2]), .request_pin_3(pins[3]), .request_pin_4(pins[4]), .nmi_pin, .acknowledge_pin_0_n,
		.acknowledge_pin_0_oe_n, .acknowledge_pin_1_n, .acknowledge_pin_1_oe_n, .ready, .low_address_data_lines,
		.ale, .rd_n, .bus_locked, .int_enable, .instr_done, .single_step_flag, .instr_prefix(tr[0]),
		.instr_seg_write(tr[1]), .instr_wait(tr[2]), .div_overflow(ev[0]), .breakpoint_instr(ev[1]),
		.overflow_trap_instr(ev[2]), .overflow_flag, .range_fail(ev[3]), .undefined_opcode(ev[4]),
		.opcode_valid(ev[5]), .opcode, .flags_pushed, .int_take, .int_req, .vector_valid_q, .vector_type_q,
		.vector_addr_q, .restart_at_start_q, .single_step_clear_q);
	ext_ctrl_model i_ext (.sys_clk, .ack_n(acknowledge_pin_0_n & acknowledge_pin_1_n), .ready,
		.lines(low_address_data_lines), .vtype(vt));
	initial forever #10 sys_clk = ~sys_clk;
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict
	// Hang guard, well above the few hundred cycles the run needs
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			give_verdict();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge sys_clk);
		wb_adr_i <= a;
		wb_we_i <= w;
		wb_dat_i <= d;
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		do @(posedge sys_clk); while (wb_ack_o !== 1'h1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		@(posedge sys_clk);
	endtask : wb
	task automatic hit(input logic [5:0] m);
		@(posedge sys_clk);
		{pins, timer_irq} <= m;
		@(posedge sys_clk);
		{pins, timer_irq} <= 6'h00;
	endtask : hit
	task automatic quiet();
		repeat (3) @(posedge sys_clk);
	endtask : quiet
	// Core side: accept one request, count strobes until the vector arrives
	task automatic take(input logic [7:0] t, input int na, input logic rs);
		int a;
		a = 0;
		do @(posedge sys_clk); while (int_req !== 1'h1);
		int_take <= 1'h1;
		@(posedge sys_clk);
		int_take <= 1'h0;
		while (vector_valid_q !== 1'h1) begin
			a += int'(ale === 1'h1);
			chk("rd_n", 1'h1, rd_n);
			chk("ack1_n", 1'h1, acknowledge_pin_1_n);
			if (ale === 1'h1) chk("locked", 1'h1, bus_locked);
			@(posedge sys_clk);
		end
		chk("type", t, vector_type_q);
		chk("addr", {t, 2'h0}, vector_addr_q);
		chk("restart", rs, restart_at_start_q);
		chk("ale", na, a);
		chk("locked", 1'h0, bus_locked);
	endtask : take
	function automatic logic [31:0] rst_val(input logic [7:0] a);
		return a < 8'h20 ? 32'h0F : (a == 8'h20 ? 32'h7 : 32'h0);
	endfunction : rst_val
	initial begin
		n = $urandom(32'h1671EFA2);
		repeat (12) @(posedge sys_clk);
		rstn <= 1'h1;
		for (int k = 0; k < 13; k++) begin
			if (k != 11) begin
				wb(8'(4 * k), 1'h0, 32'h0);
				chk("reg", rst_val(8'(4 * k)), rd);
			end
		end
		chk("oe_n", 1'h1, acknowledge_pin_0_oe_n);
		chk("oe1_n", 1'h1, acknowledge_pin_1_oe_n);
		chk("int_req", 1'h0, int_req);
		// Frozen edge detector must not see a pin pulse made while disabled
		ce <= 1'h0;
		nmi_pin <= 1'h0;
		@(posedge sys_clk);
		nmi_pin <= 1'h1;
		@(posedge sys_clk);
		ce <= 1'h1;
		quiet();
		chk("int_req", 1'h0, int_req);
		$display("test reset done");
		for (int k = 0; k < 2; k++) begin
			nmi_pin <= 1'h0;
			@(posedge sys_clk);
			nmi_pin <= 1'h1;
			take(8'h02, 0, 1'h0);
		end
		$display("test nmi done");
		for (int k = 0; k < 6; k++) begin
			@(posedge sys_clk);
			opcode <= 8'hD8 + 8'($urandom_range(7, 0));
			ev <= 6'h01 << k;
			@(posedge sys_clk);
			ev <= 6'h00;
			take(exc_t[k], 0, k == 5);
		end
		overflow_flag <= 1'h0;
		ev <= 6'h04;
		@(posedge sys_clk);
		ev <= 6'h00;
		quiet();
		chk("int_req", 1'h0, int_req);
		$display("test exceptions done");
		single_step_flag <= 1'h1;
		instr_done <= 1'h1;
		@(posedge sys_clk);
		instr_done <= 1'h0;
		take(8'h01, 0, 1'h0);
		chk("ss_clear", 1'h0, single_step_clear_q);
		flags_pushed <= 1'h1;
		@(posedge sys_clk);
		flags_pushed <= 1'h0;
		n = 0;
		repeat (4) @(posedge sys_clk) n += int'(single_step_clear_q === 1'h1);
		chk("ss_clear", 1, n);
		for (int k = 0; k < 3; k++) begin
			tr <= 3'h1 << k;
			instr_done <= 1'h1;
			@(posedge sys_clk);
			instr_done <= 1'h0;
			tr <= 3'h0;
			quiet();
			chk("int_req", 1'h0, int_req);
		end
		single_step_flag <= 1'h0;
		$display("test trace done");
		for (int k = 0; k < 4; k++)
			wb(8'(4 * mi[k]), 1'h1, 32'h07);
		hit(6'h0F);
		for (int k = 0; k < 4; k++) begin
			take(mt[k], 0, 1'h0);
			wb(8'h24, 1'h1, 32'h1 << mi[k]);
		end
		lv = $urandom_range(6, 0);
		wb(8'h14, 1'h1, 32'(lv));
		hit(6'h0A);
		take(8'h0E, 0, 1'h0);
		quiet();
		chk("int_req", 1'h0, int_req);
		wb(8'h24, 1'h1, 32'h20);
		take(8'h0C, 0, 1'h0);
		wb(8'h24, 1'h1, 32'h08);
		$display("test maskable done");
		wb(8'h0C, 1'h1, 32'h27);
		chk("oe_n", 1'h0, acknowledge_pin_0_oe_n);
		vt <= 8'($urandom);
		hit(6'h06);
		take(vt, 2, 1'h0);
		wb(8'h24, 1'h1, 32'h08);
		take(8'h0D, 0, 1'h0);
		wb(8'h24, 1'h1, 32'h10);
		$display("test linked done");
		// Second reset in mid-run must undo the linked setting
		rstn <= 1'h0;
		repeat (2) @(posedge sys_clk);
		rstn <= 1'h1;
		wb(8'h0C, 1'h0, 32'h0);
		chk("reg", rst_val(8'h0C), rd);
		chk("oe_n", 1'h1, acknowledge_pin_0_oe_n);
		$display("test second reset done");
		give_verdict();
	end
endmodule : interrupt_priority_and_ack_tb
